// ### ecu_link_model.sv
// behavioural engine control unit that takes speed requests
`timescale 1ns/1ps
`default_nettype none
module ecu_link_model
  import speed_loop_pkg::*;
(
  input wire logic       sys_clk,
  input wire speed_req_t speedReq
);
  // ==========================================================================
  // frame capture: keeps the last rpm asked for and counts the frames
  int          frames = 0;
  logic [15:0] lastRpm = 16'h0000;
  always @(posedge sys_clk) begin
    if (speedReq.valid === 1'b1) begin
      frames  <= frames + 1;
      lastRpm <= speedReq.rpm;
    end
  end
endmodule
`default_nettype wire

// ### engine_speed_control_loop.sv
// closed-loop engine speed regulator with ramped setpoint and rpm request
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module engine_speed_control_loop
  import speed_loop_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES,
  parameter int NumAnalog  = 16
) (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [31:0]                regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [31:0]                regRdata,
  input  wire logic                       engineRunning,
  input  wire logic                       engineCranking,
  input  wire logic                       engineStopping,
  input  wire logic                       generatorBreakerClosed,
  input  wire logic                       clutchEngaged,
  input  wire logic [15:0]                genVoltage,
  input  wire logic [NumAnalog-1:0][15:0] analogIn,
  output speed_req_t                      speedReq,
  output logic                            loopActive
);

  // ==========================================================================
  // helpers
  function automatic logic [31:0] mul10k(input logic [15:0] v);
    mul10k = {16'h0000, v} * SCALE_10K;
  endfunction

  function automatic logic [15:0] pickAnalog(input logic [3:0] idx);
    pickAnalog = 16'h0000;
    for (int i = 0; i < NumAnalog; i++) begin
      if (idx == i[3:0]) pickAnalog = analogIn[i];
    end
  endfunction

  function automatic logic [15:0] clampPct(input logic signed [35:0] v);
    if (v < 0) clampPct = 16'h0000;
    else if (v > $signed({20'h0_0000, PCT_FULL})) clampPct = PCT_FULL;
    else clampPct = v[15:0];
  endfunction

  // ==========================================================================
  // declarations
  cfg_t        cfg_reg;
  logic [4:0]  pinSync1_reg, pinSync2_reg;
  logic        runPrev_reg;
  logic [31:0] tickCnt_reg;
  logic        tick_reg;
  logic [7:0]  subSec_reg;
  logic [15:0] secCnt_reg;
  loop_state_t state_reg;
  logic [31:0] wspScaled_reg;
  logic [31:0] num_reg, quo_reg;
  logic [32:0] rem_reg;
  logic [15:0] den_reg;
  logic [5:0]  bitCnt_reg;
  logic        errNeg_reg;
  logic [15:0] integ_reg, cmdPct_reg;
  logic        rampBusy_reg, inBand_reg;

  logic        running, cranking, stopping, loadOk, engineStart, gateOk;
  logic [15:0] measVal, nominalVal, targetVal, errMag;
  logic [31:0] measScaled, targetScaled, rampStep;
  logic signed [17:0] errS;
  logic signed [35:0] pProd, iProd, integSum, cmdSum, rpmSum;
  logic [32:0] remShift;

  // ==========================================================================
  // pin synchronisers; loop logic reads only the second stage
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1_reg <= 5'h00;
      pinSync2_reg <= 5'h00;
      runPrev_reg  <= 1'b0;
    end else begin
      pinSync1_reg <= {clutchEngaged, generatorBreakerClosed, engineStopping,
                       engineCranking, engineRunning};
      pinSync2_reg <= pinSync1_reg;
      runPrev_reg  <= pinSync2_reg[0];
    end
  end

  assign running     = pinSync2_reg[0];
  assign cranking    = pinSync2_reg[1];
  assign stopping    = pinSync2_reg[2];
  assign loadOk      = pinSync2_reg[3] | pinSync2_reg[4];
  assign engineStart = running & ~runPrev_reg;

  // ==========================================================================
  // register writes; gains reset to about 0.100
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= CFG_RESET;
    end else if (regWrite) begin
      case (regAddr)
        OFS_OPTIONS: begin
          cfg_reg.invert    <= regWdata[OPT_INVERT_BIT];
          cfg_reg.needLoad  <= regWdata[OPT_NEEDLOAD_BIT];
          cfg_reg.spInputEn <= regWdata[OPT_SPINPUT_BIT];
          cfg_reg.spIdx     <= regWdata[OPT_SPIDX_LSB +: 4];
          cfg_reg.fbSel     <= regWdata[OPT_FBSEL_LSB +: 4];
        end
        OFS_SPEED: begin
          cfg_reg.minRpm <= regWdata[15:0];
          cfg_reg.maxRpm <= regWdata[31:16];
        end
        OFS_IDLE_DB: begin
          cfg_reg.idlePct  <= regWdata[15:0];
          cfg_reg.deadBand <= regWdata[31:16];
        end
        OFS_GAINS: begin
          cfg_reg.fastGain <= regWdata[15:0];
          cfg_reg.slowGain <= regWdata[31:16];
        end
        OFS_TIMING: begin
          cfg_reg.rampRate  <= regWdata[7:0];
          cfg_reg.loopDelay <= regWdata[TIM_DELAY_LSB +: 16];
        end
        OFS_NOMINAL: begin
          cfg_reg.nominalRef <= regWdata[15:0];
          cfg_reg.ratedVolt  <= regWdata[31:16];
        end
        OFS_FIXED: cfg_reg.fixedSp <= regWdata[15:0];
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        OFS_OPTIONS: regRdata <= {16'h0000, cfg_reg.fbSel, cfg_reg.spIdx, 5'h00,
                                  cfg_reg.spInputEn, cfg_reg.needLoad, cfg_reg.invert};
        OFS_SPEED:   regRdata <= {cfg_reg.maxRpm, cfg_reg.minRpm};
        OFS_IDLE_DB: regRdata <= {cfg_reg.deadBand, cfg_reg.idlePct};
        OFS_GAINS:   regRdata <= {cfg_reg.slowGain, cfg_reg.fastGain};
        OFS_TIMING:  regRdata <= {8'h00, cfg_reg.loopDelay, cfg_reg.rampRate};
        OFS_NOMINAL: regRdata <= {cfg_reg.ratedVolt, cfg_reg.nominalRef};
        OFS_FIXED:   regRdata <= {16'h0000, cfg_reg.fixedSp};
        OFS_STATUS:  regRdata <= {13'h0000, inBand_reg, rampBusy_reg, loopActive,
                                  cmdPct_reg};
        OFS_OUTPUT:  regRdata <= {targetVal, speedReq.rpm};
        default:     regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // loop tick and start-delay seconds
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tickCnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'b0;
    end else if (tickCnt_reg >= 32'(TickCycles - 1)) begin
      tickCnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'b1;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
      tick_reg    <= 1'b0;
    end
  end

  // seconds since the real start; saturates so a long run never wraps
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      subSec_reg <= 8'h00;
      secCnt_reg <= 16'h0000;
    end else if (engineStart || !running) begin
      subSec_reg <= 8'h00;
      secCnt_reg <= 16'h0000;
    end else if (tick_reg) begin
      if (subSec_reg == 8'(TICKS_PER_SEC - 1)) begin
        subSec_reg <= 8'h00;
        if (secCnt_reg != 16'hFFFF) secCnt_reg <= secCnt_reg + 16'h0001;
      end else begin
        subSec_reg <= subSec_reg + 8'h01;
      end
    end
  end

  // loop gate: running, not in a start/stop phase, delay over, load if asked
  assign gateOk = running & ~cranking & ~stopping & ~engineStart &
                  (secCnt_reg >= cfg_reg.loopDelay) &
                  (~cfg_reg.needLoad | loadOk);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) loopActive <= 1'b0;
    else loopActive <= gateOk;
  end

  // ==========================================================================
  // feedback, nominal and target selection
  always_comb begin
    if (cfg_reg.fbSel == FB_GEN_VOLTAGE) measVal = genVoltage;
    else measVal = pickAnalog(cfg_reg.fbSel);
    if (cfg_reg.fbSel == FB_GEN_VOLTAGE && cfg_reg.nominalRef == 16'h0000)
      nominalVal = cfg_reg.ratedVolt;
    else nominalVal = cfg_reg.nominalRef;
    if (cfg_reg.spInputEn) targetVal = pickAnalog(cfg_reg.spIdx);
    else if (cfg_reg.fixedSp != 16'h0000) targetVal = cfg_reg.fixedSp;
    else targetVal = cfg_reg.ratedVolt;
  end

  assign measScaled   = mul10k(measVal);
  assign targetScaled = mul10k(targetVal);
  // scaled by 1e4 and stepped 100 times a second: rate * nominal per tick
  assign rampStep     = {16'h0000, 8'h00, cfg_reg.rampRate} * {16'h0000, nominalVal};

  // ==========================================================================
  // working setpoint: tracks the measurement while idle, then ramps
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wspScaled_reg <= 32'h0000_0000;
      rampBusy_reg  <= 1'b0;
    end else if (tick_reg && state_reg == S_WAIT) begin
      rampBusy_reg <= 1'b0;
      if (!loopActive) begin
        wspScaled_reg <= measScaled;  // ramp starts from the actual value
      end else if (cfg_reg.rampRate == 8'h00 || cfg_reg.rampRate == 8'h64) begin
        wspScaled_reg <= targetScaled;
      end else if (wspScaled_reg + rampStep < targetScaled) begin
        wspScaled_reg <= wspScaled_reg + rampStep;
        rampBusy_reg  <= 1'b1;
      end else if (wspScaled_reg > targetScaled + rampStep) begin
        wspScaled_reg <= wspScaled_reg - rampStep;
        rampBusy_reg  <= 1'b1;
      end else begin
        wspScaled_reg <= targetScaled;
      end
    end
  end

  // ==========================================================================
  // sequencer: launch divide on tick, apply result, send the request
  assign remShift = {rem_reg[31:0], num_reg[31]};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= S_WAIT;
      num_reg    <= 32'h0000_0000;
      quo_reg    <= 32'h0000_0000;
      rem_reg    <= 33'h0_0000_0000;
      den_reg    <= 16'h0000;
      bitCnt_reg <= 6'h00;
      errNeg_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_WAIT: if (tick_reg) begin
          // scaled difference over nominal gives error in 0.01 % steps
          if (wspScaled_reg >= measScaled) num_reg <= wspScaled_reg - measScaled;
          else num_reg <= measScaled - wspScaled_reg;
          errNeg_reg <= (wspScaled_reg < measScaled) ^ cfg_reg.invert;
          den_reg    <= nominalVal;
          rem_reg    <= 33'h0_0000_0000;
          quo_reg    <= 32'h0000_0000;
          bitCnt_reg <= 6'(DIV_STEPS);
          state_reg  <= S_DIV;
        end
        S_DIV: begin
          num_reg <= {num_reg[30:0], 1'b0};
          if (remShift >= {17'h0_0000, den_reg}) begin
            rem_reg <= remShift - {17'h0_0000, den_reg};
            quo_reg <= {quo_reg[30:0], 1'b1};
          end else begin
            rem_reg <= remShift;
            quo_reg <= {quo_reg[30:0], 1'b0};
          end
          bitCnt_reg <= bitCnt_reg - 6'h01;
          if (bitCnt_reg == 6'h01) state_reg <= S_APPLY;
        end
        S_APPLY: state_reg <= S_SEND;
        S_SEND:  state_reg <= S_WAIT;
        default: state_reg <= S_WAIT;
      endcase
    end
  end

  // ==========================================================================
  // control law: fast gain on error, slow gain on accumulated error
  always_comb begin
    if (den_reg == 16'h0000) errMag = 16'h0000;
    else if (quo_reg > {16'h0000, PCT_FULL}) errMag = PCT_FULL;
    else errMag = quo_reg[15:0];
    errS     = errNeg_reg ? -$signed({2'b00, errMag}) : $signed({2'b00, errMag});
    pProd    = 36'($signed({1'b0, cfg_reg.fastGain}) * errS);
    iProd    = 36'($signed({1'b0, cfg_reg.slowGain}) * errS);
    integSum = $signed({20'h0_0000, integ_reg}) + (iProd >>> GAIN_SHIFT);
    cmdSum   = $signed({20'h0_0000, clampPct(integSum)}) + (pProd >>> GAIN_SHIFT);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      integ_reg  <= CFG_RESET.idlePct;
      cmdPct_reg <= CFG_RESET.idlePct;
      inBand_reg <= 1'b0;
    end else if (engineStart) begin
      integ_reg  <= cfg_reg.idlePct;
      cmdPct_reg <= cfg_reg.idlePct;
      inBand_reg <= 1'b0;
    end else if (state_reg == S_APPLY) begin
      if (!loopActive) begin
        integ_reg  <= cfg_reg.idlePct;
        cmdPct_reg <= cfg_reg.idlePct;
        inBand_reg <= 1'b0;
      end else if (den_reg == 16'h0000 || errMag < cfg_reg.deadBand) begin
        inBand_reg <= 1'b1;
      end else begin
        integ_reg  <= clampPct(integSum);
        cmdPct_reg <= clampPct(cmdSum);
        inBand_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // rpm request; a reversed min/max span is kept signed, not swapped
  always_comb begin
    rpmSum = ($signed({20'h0_0000, cfg_reg.maxRpm}) - $signed({20'h0_0000, cfg_reg.minRpm}))
             * $signed({20'h0_0000, cmdPct_reg});
    rpmSum = $signed({20'h0_0000, cfg_reg.minRpm})
             + rpmSum / $signed({20'h0_0000, PCT_FULL});
  end

  // one request per tick, handed to the CAN transmitter as a pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      speedReq <= '{valid: 1'b0, rpm: CFG_RESET.minRpm};
    end else begin
      speedReq.valid <= (state_reg == S_SEND);
      if (state_reg == S_SEND) speedReq.rpm <= rpmSum[15:0];
    end
  end

  // ==========================================================================
  // checks
  a_idle_inactive: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_reg == S_APPLY && !loopActive && !engineStart) |=>
      cmdPct_reg == $past(cfg_reg.idlePct))
    else $error("inactive loop did not output idle command");
  a_idle_start_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cranking || stopping) |=> !loopActive)
    else $error("loop active during start or stop phase");
  a_cmd_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmdPct_reg <= PCT_FULL && integ_reg <= PCT_FULL)
    else $error("command or integral outside 0..100 percent");
  a_band_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_reg == S_APPLY && loopActive && !engineStart && errMag < cfg_reg.deadBand)
      |=> $stable(cmdPct_reg) && $stable(integ_reg))
    else $error("command moved inside dead band");
  a_activation_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(loopActive) |-> $past(secCnt_reg >= cfg_reg.loopDelay)
      && ($past(!cfg_reg.needLoad) || $past(loadOk)))
    else $error("loop enabled before delay or without load");
  a_rpm_ends: assert property (@(posedge sys_clk) disable iff (!resetn)
    (speedReq.valid && $stable(cfg_reg.minRpm) && $stable(cfg_reg.maxRpm))
      |-> (cmdPct_reg != 16'h0000 || speedReq.rpm == cfg_reg.minRpm)
       && (cmdPct_reg != PCT_FULL || speedReq.rpm == cfg_reg.maxRpm))
    else $error("rpm request does not match range ends");
  a_ramp_bypass: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick_reg && state_reg == S_WAIT && loopActive
      && (cfg_reg.rampRate == 8'h00 || cfg_reg.rampRate == 8'h64))
      |=> wspScaled_reg == $past(targetScaled))
    else $error("disabled ramp did not apply target");
  a_ramp_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick_reg && state_reg == S_WAIT && loopActive && wspScaled_reg + rampStep
      < targetScaled && cfg_reg.rampRate != 8'h00 && cfg_reg.rampRate != 8'h64)
      |=> wspScaled_reg == $past(wspScaled_reg) + $past(rampStep))
    else $error("ramp step wrong");
  a_err_sign: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick_reg && state_reg == S_WAIT && wspScaled_reg > measScaled)
      |=> errNeg_reg == $past(cfg_reg.invert))
    else $error("error sign does not follow inversion bit");
  a_update_timing: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick_reg && state_reg == S_WAIT) |-> ##33 state_reg == S_APPLY ##2 speedReq.valid)
    else $error("loop update sequence timing wrong");

  c_activation: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(loopActive));
  c_in_band:    cover property (@(posedge sys_clk) disable iff (!resetn) $rose(inBand_reg));
  c_ramping:    cover property (@(posedge sys_clk) disable iff (!resetn) $rose(rampBusy_reg));
  c_inverted:   cover property (@(posedge sys_clk) disable iff (!resetn)
    speedReq.valid && cfg_reg.invert && loopActive);

endmodule

`default_nettype wire

// ### speed_loop_pkg.sv
// shared constants, register map and carrier types of the engine speed loop
package speed_loop_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_HZ        = 10_000_000;           // sys_clk rate
  localparam int TICK_PERIOD_MS = 10;                  // loop update period
  localparam int TICK_CYCLES   = TICK_PERIOD_MS * (CLK_HZ / 1000);
  localparam int TICKS_PER_SEC = 1000 / TICK_PERIOD_MS;
  localparam int DIV_STEPS     = 32;                   // divider iterations
  localparam int GAIN_SHIFT    = 10;                   // gains are in 1/1024

  // ==========================================================================
  // numeric scale: percent values are in 0.01 % steps
  localparam logic [15:0] PCT_FULL  = 16'h2710;        // 100.00 %
  localparam logic [31:0] SCALE_10K = 32'h0000_2710;   // fixed-point scale

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_OPTIONS = 8'h00;
  localparam logic [7:0] OFS_SPEED   = 8'h04;
  localparam logic [7:0] OFS_IDLE_DB = 8'h08;
  localparam logic [7:0] OFS_GAINS   = 8'h0C;
  localparam logic [7:0] OFS_TIMING  = 8'h10;
  localparam logic [7:0] OFS_NOMINAL = 8'h14;
  localparam logic [7:0] OFS_FIXED   = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_OUTPUT  = 8'h20;

  // option and timing word field positions
  localparam int OPT_INVERT_BIT   = 0;
  localparam int OPT_NEEDLOAD_BIT = 1;
  localparam int OPT_SPINPUT_BIT  = 2;
  localparam int OPT_SPIDX_LSB    = 8;
  localparam int OPT_FBSEL_LSB    = 12;
  localparam int TIM_DELAY_LSB    = 8;
  localparam logic [3:0] FB_GEN_VOLTAGE = 4'h0;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic        invert;
    logic        needLoad;
    logic        spInputEn;
    logic [3:0]  spIdx;
    logic [3:0]  fbSel;
    logic [15:0] minRpm;
    logic [15:0] maxRpm;
    logic [15:0] idlePct;
    logic [15:0] deadBand;
    logic [15:0] fastGain;
    logic [15:0] slowGain;
    logic [7:0]  rampRate;
    logic [15:0] loopDelay;
    logic [15:0] nominalRef;
    logic [15:0] ratedVolt;
    logic [15:0] fixedSp;
  } cfg_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] rpm;
  } speed_req_t;

  typedef enum logic [3:0] {
    S_WAIT  = 4'b0001,
    S_DIV   = 4'b0010,
    S_APPLY = 4'b0100,
    S_SEND  = 4'b1000
  } loop_state_t;

  // ==========================================================================
  // values after reset
  localparam cfg_t CFG_RESET = '{
    invert: 1'b0, needLoad: 1'b0, spInputEn: 1'b0, spIdx: 4'h0, fbSel: 4'h0,
    minRpm: 16'h05DC, maxRpm: 16'h0708, idlePct: 16'h1388, deadBand: 16'h0000,
    fastGain: 16'h0066, slowGain: 16'h0066, rampRate: 8'h01,
    loopDelay: 16'h000A, nominalRef: 16'h0000, ratedVolt: 16'h0000,
    fixedSp: 16'h0000};

endpackage

// ### testbench.sv
// self-checking bench of the engine speed loop
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import speed_loop_pkg::*;
  localparam int TC = 50; // short tick, keeps the start delay cheap
  logic        sys_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic        engineRunning = 1'b0, engineCranking = 1'b0, breaker = 1'b0;
  logic        engineStopping = 1'b0, clutchEngaged = 1'b0;
  logic [15:0][15:0] analogIn = '0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000, regRdata, rd;
  logic [15:0] genVoltage = 16'h0000, cmd;
  speed_req_t  speedReq;
  logic        loopActive;
  int          fails = 0, total_checks = 0, cycles = 0;
  // ==========================================================================
  // design and far side
  engine_speed_control_loop #(.TickCycles(TC)) dut (
    .sys_clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .engineRunning, .engineCranking, .engineStopping,
    .generatorBreakerClosed(breaker), .clutchEngaged, .genVoltage,
    .analogIn, .speedReq, .loopActive);
  ecu_link_model ecu (.sys_clk, .speedReq);
  // clock, and a cycle ceiling so a hang still ends in the verdict
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      end_sim();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdr(logic [7:0] a);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask
  // a tick in flight may still carry old settings, so callers wait several
  task automatic waitFrames(int n);
    int f;
    f = ecu.frames + n;
    while (ecu.frames < f) @(posedge sys_clk);
  endtask
  function automatic logic [31:0] mapRpm(int mn, int mx, int p);
    return 32'(16'(mn + (mx - mn) * p / 10000));
  endfunction
  task automatic end_sim();
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk("rpm", speedReq.rpm, 32'h0000_05DC);
    chk("active", loopActive, 32'h0000_0000);
    rdr(OFS_GAINS);
    chk("gains", rd, 32'h0066_0066);
    rdr(8'hF0);
    chk("unmapped", rd, 32'h0000_0000);
  endtask
  task automatic t_map();
    int p[3] = '{0, 2500, 10000};
    foreach (p[i]) begin
      wr(OFS_SPEED, 32'h0708_05DC);
      wr(OFS_IDLE_DB, 32'(p[i]));
      waitFrames(3);
      chk("rpm up", ecu.lastRpm, mapRpm(1500, 1800, p[i]));
      wr(OFS_SPEED, 32'h03E8_07D0);
      waitFrames(3);
      chk("rpm down", ecu.lastRpm, mapRpm(2000, 1000, p[i]));
    end
  endtask
  task automatic t_loop();
    int k;
    wr(OFS_SPEED, 32'h0708_05DC);
    wr(OFS_IDLE_DB, 32'h0000_1388);
    wr(OFS_NOMINAL, 32'h0000_03E8);
    wr(OFS_FIXED, 32'h0000_03E8);
    wr(OFS_TIMING, 32'h0000_0100); // one second delay, ramp off
    genVoltage <= 16'h01F4; // half the setpoint
    engineCranking <= 1'b1;
    waitFrames(3);
    chk("crank", ecu.lastRpm, mapRpm(1500, 1800, 5000));
    engineCranking <= 1'b0;
    engineRunning <= 1'b1;
    repeat (90 * TC) @(posedge sys_clk);
    chk("early", loopActive, 32'h0000_0000);
    for (k = 0; k < 20 * TC && loopActive !== 1'b1; k++) @(posedge sys_clk);
    chk("late", loopActive, 32'h0000_0001);
    rdr(OFS_STATUS);
    cmd = rd[15:0];
    waitFrames(10);
    rdr(OFS_STATUS);
    chk("rise", 32'(rd[15:0] > cmd), 32'h0000_0001);
    wr(OFS_IDLE_DB, 32'h2710_1388); // band wider than the error
    waitFrames(3);
    rdr(OFS_STATUS);
    cmd = rd[15:0];
    waitFrames(5);
    rdr(OFS_STATUS);
    chk("band", 32'(rd[15:0]), 32'(cmd));
    wr(OFS_IDLE_DB, 32'h0000_1388);
    wr(OFS_OPTIONS, 32'h0000_0001);
    waitFrames(10);
    rdr(OFS_STATUS);
    chk("fall", 32'(rd[15:0] < cmd), 32'h0000_0001);
    wr(OFS_OPTIONS, 32'h0000_0002);
    repeat (5) @(posedge sys_clk);
    chk("no load", loopActive, 32'h0000_0000);
    breaker <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("load", loopActive, 32'h0000_0001);
    // both load pins flip at once, so a dropped clutch shows as a gap
    breaker <= 1'b0;
    clutchEngaged <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("clutch", loopActive, 32'h0000_0001);
  endtask
  // target selection read from the output word, nominal and feedback selection seen through the dead band flag
  task automatic t_select();
    rdr(OFS_OUTPUT);
    chk("fixed sp", rd[31:16], 32'h0000_03E8);
    wr(OFS_FIXED, 32'h0000_0000);
    wr(OFS_NOMINAL, 32'h07D0_0000); // nominal left at 0, rated 2000
    analogIn[3] <= 16'h0123;
    analogIn[9] <= 16'h03E8;
    rdr(OFS_OUTPUT);
    chk("rated sp", rd[31:16], 32'h0000_07D0);
    wr(OFS_OPTIONS, 32'h0000_0304); // setpoint from input 3
    rdr(OFS_OUTPUT);
    chk("input sp", rd[31:16], 32'h0000_0123);
    wr(OFS_OPTIONS, 32'h0000_0000);
    wr(OFS_FIXED, 32'h0000_03E8);
    wr(OFS_IDLE_DB, 32'h07D0_1388); // 20 % band
    waitFrames(3);
    rdr(OFS_STATUS);
    chk("rated nominal", rd[18], 32'h0000_0000);
    wr(OFS_NOMINAL, 32'h07D0_1388); // nominal 5000
    waitFrames(3);
    rdr(OFS_STATUS);
    chk("own nominal", rd[18], 32'h0000_0001);
    wr(OFS_OPTIONS, 32'h0000_9000); // feedback from input 9
    genVoltage <= 16'h0000;
    waitFrames(3);
    rdr(OFS_STATUS);
    chk("input fb", rd[18], 32'h0000_0001);
    wr(OFS_OPTIONS, 32'h0000_0000);
    genVoltage <= 16'h01F4;
  endtask
  // error grows 0.01 % a tick while ramping, so a 0.2 % band holds a while
  task automatic t_ramp();
    engineCranking <= 1'b1;
    wr(OFS_IDLE_DB, 32'h0014_1388);
    wr(OFS_TIMING, 32'h0000_0101); // 1 %/s
    waitFrames(3);
    chk("crank run", ecu.lastRpm, mapRpm(1500, 1800, 5000));
    engineCranking <= 1'b0;
    waitFrames(8);
    rdr(OFS_STATUS);
    chk("ramp busy", rd[17], 32'h0000_0001);
    chk("ramp slow", rd[18], 32'h0000_0001);
    waitFrames(25);
    rdr(OFS_STATUS);
    chk("ramp end", rd[18], 32'h0000_0000);
    wr(OFS_TIMING, 32'h0000_0164); // 100 %/s skips the ramp
    waitFrames(2);
    rdr(OFS_STATUS);
    chk("ramp off", rd[17], 32'h0000_0000);
  endtask
  task automatic t_stop();
    @(posedge sys_clk);
    engineStopping <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("stopping", loopActive, 32'h0000_0000);
    engineRunning <= 1'b0;
    waitFrames(3);
    chk("idle", ecu.lastRpm, mapRpm(1500, 1800, 5000));
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_map();
    t_loop();
    t_select();
    t_ramp();
    t_stop();
    end_sim();
  end
endmodule
`default_nettype wire
